// File: bench/osc_model.sv
// oscillator model, sped up so that the divided rates down to 32 Hz fit a short run
`default_nettype none
module osc_model
#(
  parameter int HALF_NS = 20
)
(
  output var logic osc
);
  timeunit 1ns;
  timeprecision 100ps;
  // odd start offset keeps its edges away from the bench clock edges
  initial
  begin
    osc = 1'b0;
    #3;
    forever #(HALF_NS) osc = ~osc;
  end
endmodule : osc_model
`default_nettype wire

// File: bench/rtc_clock_out_timer_tb.sv
// self-checking bench for the clock output and countdown timer
`default_nettype none
module rtc_clock_out_timer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk, arst_n, ce, osc, wr, rd, pin, oe, ev;
  logic [7:0] addr, wdata, rdata, v;
  int         error_cnt, cmp_count, cyc, n;

  rtc_clock_out_timer dut
  (
    .clk(clk), .arst_n(arst_n), .ce(ce), .osc_32k(osc), .reg_wr_en(wr), .reg_rd_en(rd),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .square_wave_out_pin_o(pin),
    .square_wave_out_pin_oe(oe), .countdown_event(ev)
  );
  osc_model u_osc (.osc(osc));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang guard: the longest waits add up to about 52000 cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      error_cnt++;
      conclude();
    end
  end

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s exp %0h got %0h", s, e, g);
    end
  endtask : chk
  // bus tasks start and end on a falling edge, leaving one idle cycle
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask : wr_reg
  // reads at clk rate, far above source
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
    @(negedge clk);
  endtask : rd_reg
  // cycles between two rising edges of the pin (s=0) or the event (s=1)
  task automatic per(input logic s, output int p);
    int k;
    logic o, c;
    k = 0;
    p = 0;
    o = 1'b1;
    repeat (25000)
    begin
      @(posedge clk);
      #1;
      c = s ? ev : pin;
      if (k == 1) p++;
      if (c === 1'b1 && o !== 1'b1) k++;
      if (k == 2) break;
      o = c;
    end
    if (k != 2) p = 0;
    @(negedge clk);
  endtask : per
  // over len cycles: cycles with the event high (s=1) or pin changes (s=0)
  task automatic quiet(input logic s, input int len, output int k);
    logic o;
    k = 0;
    o = pin;
    repeat (len)
    begin
      @(negedge clk);
      if (s ? (ev !== 1'b0) : (pin !== o)) k++;
      o = pin;
    end
  endtask : quiet

  task automatic t_reset();
    chk("oe", 1, oe);
    rd_reg(8'h0D, v);
    chk("clkctl", 8'h80, v);
    rd_reg(8'h0E, v);
    chk("tmrctl", 8'h03, v);
    wr_reg(8'h10, 8'hFF);
    rd_reg(8'h10, v);
    chk("unmapped", 8'h00, v);
  endtask : t_reset
  task automatic t_regs();
    logic [7:0] t [4] = '{8'h00, 8'h5A, 8'hA5, 8'hFF};
    wr_reg(8'h0D, 8'hFF);
    rd_reg(8'h0D, v);
    chk("clkctl", 8'h83, v);
    wr_reg(8'h0E, 8'h7C);
    rd_reg(8'h0E, v);
    chk("tmrctl", 8'h00, v);
    foreach (t[i])
    begin
      wr_reg(8'h0F, t[i]);
      rd_reg(8'h0F, v);
      chk("value", t[i], v);
    end
  endtask : t_regs
  // the slowest rate needs 32768 oscillator cycles, too long for this run
  task automatic t_square_wave_out_pin();
    int e [3] = '{5, 160, 5120};
    for (int r = 0; r < 3; r++)
    begin
      wr_reg(8'h0D, {6'h20, r[1:0]});
      per(1'b0, n);
      chk("pin period", e[r], n);
    end
    wr_reg(8'h0D, 8'h00);
    chk("oe off", 0, oe);
  endtask : t_square_wave_out_pin
  task automatic t_count();
    logic [7:0] ld [4] = '{8'h01, 8'h03, 8'hFF, 8'h02};
    logic [1:0] sr [4] = '{2'h0, 2'h0, 2'h0, 2'h1};
    int e [4] = '{40, 120, 10200, 5120};
    foreach (ld[i])
    begin
      wr_reg(8'h0E, 8'h00);
      wr_reg(8'h0F, ld[i]);
      wr_reg(8'h0E, {6'h20, sr[i]});
      per(1'b1, n);
      chk("event period", e[i], n);
      rd_reg(8'h0F, v);
      chk("reload", ld[i], v);
    end
    wr_reg(8'h0E, 8'h00);
    quiet(1'b1, 300, n);
    chk("stopped events", 0, n);
    wr_reg(8'h0F, 8'h00);
    wr_reg(8'h0E, 8'h80);
    quiet(1'b1, 300, n);
    chk("zero events", 0, n);
    rd_reg(8'h0F, v);
    chk("zero parked", 8'h00, v);
  endtask : t_count
  // ce low must freeze the count and ignore a write; one tick may fall between reads
  task automatic t_freeze();
    logic [7:0] a;
    wr_reg(8'h0E, 8'h00);
    wr_reg(8'h0F, 8'hFF);
    wr_reg(8'h0E, 8'h80);
    repeat (100) @(negedge clk);
    rd_reg(8'h0F, a);
    ce = 1'b0;
    wr_reg(8'h0F, 8'h00);
    repeat (400) @(negedge clk);
    ce = 1'b1;
    rd_reg(8'h0F, v);
    chk("frozen count", 1, (a - v) <= 8'h01);
  endtask : t_freeze
  // slow rates: the prescaler is far from its 1 Hz edge here, so nothing may move
  task automatic t_slow();
    wr_reg(8'h0D, 8'h83);
    quiet(1'b0, 3000, n);
    chk("1 Hz pin edges", 0, n);
    for (int s = 2; s < 4; s++)
    begin
      wr_reg(8'h0E, 8'h00);
      wr_reg(8'h0F, 8'h01);
      wr_reg(8'h0E, {6'h20, s[1:0]});
      quiet(1'b1, 3000, n);
      chk("slow source events", 0, n);
    end
    // park at slowest source when idle
    wr_reg(8'h0E, 8'h03);
    rd_reg(8'h0E, v);
    chk("idle tmrctl", 8'h03, v);
  endtask : t_slow

  task automatic conclude();
    if (error_cnt == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  initial
  begin
    arst_n = 1'b0;
    ce = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    error_cnt = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_regs();
    t_square_wave_out_pin();
    t_count();
    t_freeze();
    t_slow();
    conclude();
  end
endmodule : rtc_clock_out_timer_tb
`default_nettype wire

// File: bench/rtc_timer_chk.sv
// port assertions for the clock output and countdown timer
`default_nettype none
module rtc_timer_chk
(
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       ce,
  input wire logic       reg_wr_en,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       square_wave_out_pin_oe,
  input wire logic       countdown_event
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // requests the port really takes; ce low ignores them
  logic rd_t;
  logic wr_t;
  assign rd_t = ce & reg_rd_en;
  assign wr_t = ce & reg_wr_en;

  a_event_pulse: assert property (countdown_event |=> !countdown_event [*4])
    else $error("event longer than one cycle");
  a_rdata_hold: assert property (!rd_t |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (rd_t && !(reg_addr inside {8'h0D, 8'h0E, 8'h0F}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_reserved_zero: assert property (rd_t && (reg_addr == 8'h0D || reg_addr == 8'h0E) |=> reg_rdata[6:2] == 5'h00)
    else $error("control bits 6..2 not zero");
  a_oe_follows: assert property (wr_t && reg_addr == 8'h0D |-> ##2 square_wave_out_pin_oe == $past(reg_wdata[7], 2))
    else $error("pin enable does not follow write");
  a_ctrl_readback: assert property (wr_t && reg_addr == 8'h0E ##1 !wr_t ##1 rd_t && reg_addr == 8'h0E
    |=> reg_rdata == {$past(reg_wdata[7], 3), 5'h00, $past(reg_wdata[1:0], 3)})
    else $error("timer control readback wrong");
  // mirror of the run bit, built only from writes the port really took
  logic run_seen_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      run_seen_q <= 1'b0;
    else if (wr_t && reg_addr == 8'h0E)
      run_seen_q <= reg_wdata[7];
  end
  // an event launched at the previous edge needs the run bit set before that edge;
  // a restart soon after a stop is legal, so no fixed quiet window is used
  a_stop_quiet: assert property (countdown_event && $past(ce) |-> $past(run_seen_q))
    else $error("event while stopped");
  a_zero_quiet: assert property (wr_t && reg_addr == 8'h0F && reg_wdata == 8'h00 |=> ##1 !countdown_event [*8])
    else $error("event from zero load");
endmodule : rtc_timer_chk
bind rtc_clock_out_timer rtc_timer_chk chk_i
(
  .clk(clk), .arst_n(arst_n), .ce(ce), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .square_wave_out_pin_oe(square_wave_out_pin_oe), .countdown_event(countdown_event)
);
`default_nettype wire

// File: rtl/rtc_clock_out_timer.sv
// clock output selector and 8-bit countdown timer with byte register port
// Function
// (RQ1) enable bit drives pin, else high impedance
// (RQ2) rate field picks 32768, 1024, 32, 1 Hz
// (RQ3) countdown value is readable writable binary counter
// (RQ4) run bit starts and stops the countdown
// (RQ5) source field picks 4096, 64, 1, 1/60 Hz
// (RQ6) software selects slowest source when idle
// (RQ7) host bus clock twice source for readback
// (RQ8) any load 00h-FFh; period n over rate
// (RQ9) interrupt control lives in another register
// (RQ10) decrement per tick, event and reload at zero
`default_nettype none
module rtc_clock_out_timer
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       ce,
  input  wire logic       osc_32k,
  input  wire logic       reg_wr_en,
  input  wire logic       reg_rd_en,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            square_wave_out_pin_o,
  output logic            square_wave_out_pin_oe,
  output logic            countdown_event
);
  // oscillator synchroniser and edge detector
  logic osc_meta_q;
  logic osc_sync_q;
  logic osc_prev_q;
  logic osc_rise;

  // configuration registers
  logic       clock_output_enable_q;
  logic       clock_output_enable_d;
  logic [1:0] clock_output_rate_select_q;
  logic [1:0] clock_output_rate_select_d;
  logic       countdown_run_q;
  logic       countdown_run_d;
  logic [1:0] countdown_source_select_q;
  logic [1:0] countdown_source_select_d;

  // countdown state
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic [7:0] reload_q;
  logic [7:0] reload_d;
  logic       event_q;
  logic       event_d;
  logic       source_tick;

  // register read data and pin drivers
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       pin_q;
  logic       pin_d;
  logic       pin_oe_q;
  logic       pin_oe_d;

  logic [rtc_timer_pkg::PRESCALE_BITS-1:0] div_count;
  logic [rtc_timer_pkg::PRESCALE_BITS-1:0] rise_tick;
  logic                                    minute_tick;

  // the oscillator is asynchronous to clk: two flops before any use
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      osc_meta_q <= 1'h0;
      osc_sync_q <= 1'h0;
      osc_prev_q <= 1'h0;
    end
    else if (ce)
    begin
      osc_meta_q <= osc_32k;
      osc_sync_q <= osc_meta_q;
      osc_prev_q <= osc_sync_q;
    end
  end

  assign osc_rise = osc_sync_q & ~osc_prev_q;

  rtc_prescaler u_prescaler
  (
    .clk         (clk),
    .arst_n      (arst_n),
    .ce          (ce),
    .osc_rise    (osc_rise),
    .div_count   (div_count),
    .rise_tick   (rise_tick),
    .minute_tick (minute_tick)
  );

  // register writes; bits 6 to 2 of both control registers are not stored
  always_comb
  begin
    clock_output_enable_d      = clock_output_enable_q;
    clock_output_rate_select_d = clock_output_rate_select_q;
    countdown_run_d            = countdown_run_q;
    countdown_source_select_d  = countdown_source_select_q;
    if (reg_wr_en && reg_addr == rtc_timer_pkg::ADDR_CLOCK_OUTPUT_CONTROL)
    begin
      clock_output_enable_d      = reg_wdata[rtc_timer_pkg::CLOCK_OUTPUT_ENABLE_BIT];
      clock_output_rate_select_d = reg_wdata[1:0];
    end
    if (reg_wr_en && reg_addr == rtc_timer_pkg::ADDR_COUNTDOWN_CONTROL)
    begin
      // (RQ4) run bit write
      countdown_run_d           = reg_wdata[rtc_timer_pkg::COUNTDOWN_RUN_BIT];
      countdown_source_select_d = reg_wdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      clock_output_enable_q      <= rtc_timer_pkg::CLOCK_OUTPUT_ENABLE_RST;
      clock_output_rate_select_q <= rtc_timer_pkg::CLOCK_OUTPUT_RATE_RST;
      countdown_run_q            <= rtc_timer_pkg::COUNTDOWN_RUN_RST;
      // (RQ6) idle at slowest source
      countdown_source_select_q  <= rtc_timer_pkg::COUNTDOWN_SOURCE_RST;
    end
    else if (ce)
    begin
      clock_output_enable_q      <= clock_output_enable_d;
      clock_output_rate_select_q <= clock_output_rate_select_d;
      countdown_run_q            <= countdown_run_d;
      countdown_source_select_q  <= countdown_source_select_d;
    end
  end

  // (RQ5) source clock select
  always_comb
  begin
    unique case (countdown_source_select_q)
      rtc_timer_pkg::SEL_0: source_tick = rise_tick[rtc_timer_pkg::TICK_4096HZ];
      rtc_timer_pkg::SEL_1: source_tick = rise_tick[rtc_timer_pkg::TICK_64HZ];
      rtc_timer_pkg::SEL_2: source_tick = rise_tick[rtc_timer_pkg::TICK_1HZ];
      rtc_timer_pkg::SEL_3: source_tick = minute_tick;
    endcase
  end

  // countdown: a write loads both the live count and the reload value;
  // a load of 00h leaves the counter parked at zero, so no events follow
  always_comb
  begin
    count_d  = count_q;
    reload_d = reload_q;
    event_d  = 1'h0;
    if (reg_wr_en && reg_addr == rtc_timer_pkg::ADDR_COUNTDOWN_VALUE)
    begin
      // (RQ8) accept any load value
      count_d  = reg_wdata;
      reload_d = reg_wdata;
    end
    // (RQ4) count only while running
    else if (countdown_run_q && source_tick && count_q != 8'h00)
    begin
      // (RQ10) event and reload at zero
      if (count_q == 8'h01)
      begin
        count_d = reload_q;
        event_d = 1'h1;
      end
      // (RQ3) binary decrement by one
      else
        count_d = count_q - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count_q  <= rtc_timer_pkg::COUNTDOWN_VALUE_RST;
      reload_q <= rtc_timer_pkg::COUNTDOWN_VALUE_RST;
      event_q  <= 1'h0;
    end
    else if (ce)
    begin
      count_q  <= count_d;
      reload_q <= reload_d;
      event_q  <= event_d;
    end
  end

  // (RQ9) event only, flag lives elsewhere
  assign countdown_event = event_q;

  // read data: registered, unmapped addresses read zero
  always_comb
  begin
    rdata_d = rdata_q;
    if (reg_rd_en)
    begin
      unique case (reg_addr)
        rtc_timer_pkg::ADDR_CLOCK_OUTPUT_CONTROL:
          rdata_d = {clock_output_enable_q, 5'h00, clock_output_rate_select_q};
        rtc_timer_pkg::ADDR_COUNTDOWN_CONTROL:
          rdata_d = {countdown_run_q, 5'h00, countdown_source_select_q};
        // (RQ3) live count readback
        rtc_timer_pkg::ADDR_COUNTDOWN_VALUE:
          rdata_d = count_q;
        default:
          rdata_d = 8'h00;
      endcase
    end
  end

  // pin level and enable; registered so the pin never glitches on a mux change
  always_comb
  begin
    // (RQ2) output rate select
    unique case (clock_output_rate_select_q)
      rtc_timer_pkg::SEL_0: pin_d = osc_prev_q;
      rtc_timer_pkg::SEL_1: pin_d = div_count[rtc_timer_pkg::DIV_1024HZ_BIT];
      rtc_timer_pkg::SEL_2: pin_d = div_count[rtc_timer_pkg::DIV_32HZ_BIT];
      rtc_timer_pkg::SEL_3: pin_d = div_count[rtc_timer_pkg::DIV_1HZ_BIT];
    endcase
    // (RQ1) drive only when enabled
    pin_oe_d = clock_output_enable_q;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_q  <= 8'h00;
      pin_q    <= 1'h0;
      pin_oe_q <= 1'h0;
    end
    else if (ce)
    begin
      rdata_q  <= rdata_d;
      pin_q    <= pin_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  assign reg_rdata              = rdata_q;
  assign square_wave_out_pin_o  = pin_q;
  assign square_wave_out_pin_oe = pin_oe_q;
endmodule : rtc_clock_out_timer
`default_nettype wire

// File: rtl/rtc_prescaler.sv
// divide chain from the 32.768 kHz oscillator edges down to one minute
`default_nettype none
module rtc_prescaler
(
  input  wire logic                                   clk,
  input  wire logic                                   arst_n,
  input  wire logic                                   ce,
  input  wire logic                                   osc_rise,
  output logic [rtc_timer_pkg::PRESCALE_BITS-1:0]     div_count,
  output logic [rtc_timer_pkg::PRESCALE_BITS-1:0]     rise_tick,
  output logic                                        minute_tick
);
  logic [rtc_timer_pkg::PRESCALE_BITS-1:0] count_q;
  logic [rtc_timer_pkg::PRESCALE_BITS-1:0] count_d;
  logic [5:0]                              sec_q;
  logic [5:0]                              sec_d;

  assign div_count = count_q;

  // one tick per rising edge of each divider bit
  genvar k;
  generate
    for (k = 0; k < rtc_timer_pkg::PRESCALE_BITS; k++)
    begin : g_tick
      assign rise_tick[k] = osc_rise & count_d[k] & ~count_q[k];
    end
  endgenerate

  assign minute_tick = rise_tick[rtc_timer_pkg::TICK_1HZ] && (sec_q == rtc_timer_pkg::SECONDS_PER_MINUTE - 6'h01);

  // free-running count, plus a modulo-60 second counter for the slowest rate
  always_comb
  begin
    count_d = osc_rise ? count_q + 15'h0001 : count_q;
    sec_d   = sec_q;
    if (minute_tick)
      sec_d = 6'h00;
    else if (rise_tick[rtc_timer_pkg::TICK_1HZ])
      sec_d = sec_q + 6'h01;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      count_q <= 15'h0000;
      sec_q   <= 6'h00;
    end
    else if (ce)
    begin
      count_q <= count_d;
      sec_q   <= sec_d;
    end
  end
endmodule : rtc_prescaler
`default_nettype wire

// File: rtl/rtc_timer_pkg.sv
// constants for the clock output selector and countdown timer
`default_nettype none
package rtc_timer_pkg;
  // register addresses on the byte register port
  localparam logic [7:0] ADDR_CLOCK_OUTPUT_CONTROL = 8'h0D;
  localparam logic [7:0] ADDR_COUNTDOWN_CONTROL    = 8'h0E;
  localparam logic [7:0] ADDR_COUNTDOWN_VALUE      = 8'h0F;

  // field positions
  localparam int CLOCK_OUTPUT_ENABLE_BIT = 7;
  localparam int COUNTDOWN_RUN_BIT       = 7;

  // reset values
  localparam logic       CLOCK_OUTPUT_ENABLE_RST      = 1'h1;
  localparam logic [1:0] CLOCK_OUTPUT_RATE_RST        = 2'h0;
  localparam logic       COUNTDOWN_RUN_RST            = 1'h0;
  localparam logic [1:0] COUNTDOWN_SOURCE_RST         = 2'h3;
  localparam logic [7:0] COUNTDOWN_VALUE_RST          = 8'h00;

  // output rate and source encodings
  localparam logic [1:0] SEL_0 = 2'h0;
  localparam logic [1:0] SEL_1 = 2'h1;
  localparam logic [1:0] SEL_2 = 2'h2;
  localparam logic [1:0] SEL_3 = 2'h3;

  // prescaler: bit k of the ripple count toggles at 32768 / 2^(k+1) Hz
  localparam int PRESCALE_BITS  = 15;
  localparam int DIV_1024HZ_BIT = 4;
  localparam int DIV_32HZ_BIT   = 9;
  localparam int DIV_1HZ_BIT    = 14;
  localparam int TICK_4096HZ    = 2;
  localparam int TICK_64HZ      = 8;
  localparam int TICK_1HZ       = 14;
  localparam logic [5:0] SECONDS_PER_MINUTE = 6'h3C;
endpackage : rtc_timer_pkg
`default_nettype wire
